//--- hdl/direct_input_mode_control.sv
// Behaviour
// - Reset maps inputs a, b to ch2, ch3
// - Each input has its own programmable channel map
// - Channel command ORs register, PWM, mapped inputs
// - Input pin levels readable in a monitor register
// - Monitor keeps updating during fail-safe mode
// - Control low, input high: fail-safe, default channel on
// - Control low, both inputs low: sleep mode
// - Control low resets all writable serial registers to default
// - Sleep conditions disable both undervoltage detectors
// - Sleep conditions refuse serial transfers, output released
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module direct_input_mode_control
    import direct_input_pkg::*;
#(
    parameter int unsigned NUM_CH = 8
)
(
    // Clock, reset and enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,

    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,

    // Host pins, asynchronous
    input  wire logic              direct_input_a,
    input  wire logic              direct_input_b,
    input  wire logic              ctrl_pin,

    // Internal PWM generator outputs, same clock
    input  wire logic [1:0]        pwm_gen_out,

    // Channel commands and mode outputs
    output logic [NUM_CH-1:0]      channel_on,
    output logic                   uv_detect_en,
    output logic                   serial_port_en,
    output logic                   sleep_mode,
    output logic                   limp_home_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks

    // Default channels must exist and each PWM map must fit in a half word
    if (NUM_CH < 4 || NUM_CH > 16)
    begin : g_bad_num_ch
        $error("NUM_CH must lie between 4 and 16");
    end

    localparam logic [NUM_CH-1:0] MAP_A_RST = NUM_CH'(1) << DEF_CH_A;
    localparam logic [NUM_CH-1:0] MAP_B_RST = NUM_CH'(1) << DEF_CH_B;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    pins_t pins_s1_q;
    pins_t pins_s2_q;
    pins_t pins_raw;

    // Pins gathered into one word so both stages move together
    assign pins_raw = '{ctrl: ctrl_pin, in_b: direct_input_b, in_a: direct_input_a};

    // Only the second stage is read by logic; the first may be metastable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pins_s1_q <= PINS_RST;
            pins_s2_q <= PINS_RST;
        end
        else if (clk_en)
        begin
            pins_s1_q <= pins_raw;
            pins_s2_q <= pins_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decision

    logic  ctrl_low;
    logic  any_input;
    mode_t mode_d;
    mode_t mode_q;

    assign ctrl_low  = ~pins_s2_q.ctrl;
    assign any_input = pins_s2_q.in_a | pins_s2_q.in_b;

    // Fail-safe beats sleep whenever an input is high under a low control pin
    assign mode_d = !ctrl_low  ? MODE_NORMAL
                  : any_input  ? MODE_LIMP
                  :              MODE_SLEEP;

    // Registered mode feeds the bus refusal; the mode flags are its twins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= MODE_NORMAL;
        end
        else if (clk_en)
        begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic        in_sleep;
    logic        access;
    logic        commit;
    logic        wr_commit;
    logic        sel_out;
    logic        sel_map_a;
    logic        sel_map_b;
    logic        sel_pwm;
    logic        sel_mon;
    logic        sel_stat;
    logic        mapped;
    logic [31:0] wmask;

    assign in_sleep = (mode_q == MODE_SLEEP);

    // Access phase waits one cycle so every answer comes from a flip-flop
    assign access    = psel & penable & ~pready;
    assign commit    = psel & penable & pready;
    assign wr_commit = commit & pwrite & ~pslverr;

    // Full byte address compare; aliases of a register answer as unmapped
    assign sel_out   = (paddr == OUTPUT_REG_OFS);
    assign sel_map_a = (paddr == MAP_A_OFS);
    assign sel_map_b = (paddr == MAP_B_OFS);
    assign sel_pwm   = (paddr == PWM_MAP_OFS);
    assign sel_mon   = (paddr == LEVEL_MONITOR_OFS);
    assign sel_stat  = (paddr == MODE_STATUS_OFS);
    assign mapped    = sel_out | sel_map_a | sel_map_b | sel_pwm | sel_mon | sel_stat;

    // Byte strobes widen into a bit mask
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Serial-accessible registers

    logic [NUM_CH-1:0] output_reg_q;
    logic [NUM_CH-1:0] input_a_channel_map_q;
    logic [NUM_CH-1:0] input_b_channel_map_q;
    logic [31:0]       pwm_map_q;
    logic [1:0]        input_level_monitor_q;

    // Narrow registers widened to the bus word for merging and reading
    logic [31:0] out_ext;
    logic [31:0] map_a_ext;
    logic [31:0] map_b_ext;

    assign out_ext   = {{(32-NUM_CH){1'b0}}, output_reg_q};
    assign map_a_ext = {{(32-NUM_CH){1'b0}}, input_a_channel_map_q};
    assign map_b_ext = {{(32-NUM_CH){1'b0}}, input_b_channel_map_q};

    // Byte-lane merge keeps the lanes that a partial write leaves alone
    logic [31:0] out_wr;
    logic [31:0] map_a_wr;
    logic [31:0] map_b_wr;
    logic [31:0] pwm_wr;

    assign out_wr   = (out_ext & ~wmask) | (pwdata & wmask);
    assign map_a_wr = (map_a_ext & ~wmask) | (pwdata & wmask);
    assign map_b_wr = (map_b_ext & ~wmask) | (pwdata & wmask);
    assign pwm_wr   = (pwm_map_q & ~wmask) | (pwdata & wmask);

    // Bits above each PWM map are reserved and never store
    logic [31:0] pwm_keep;

    assign pwm_keep = {{(16-NUM_CH){1'b0}}, {NUM_CH{1'b1}},
                       {(16-NUM_CH){1'b0}}, {NUM_CH{1'b1}}};

    // A low control pin holds the whole bank at its defaults
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            output_reg_q          <= OUTPUT_REG_RST[NUM_CH-1:0];
            input_a_channel_map_q <= MAP_A_RST;
            input_b_channel_map_q <= MAP_B_RST;
            pwm_map_q             <= PWM_MAP_RST;
        end
        else if (clk_en)
        begin
            if (ctrl_low)
            begin
                output_reg_q          <= OUTPUT_REG_RST[NUM_CH-1:0];
                input_a_channel_map_q <= MAP_A_RST;
                input_b_channel_map_q <= MAP_B_RST;
                pwm_map_q             <= PWM_MAP_RST;
            end
            else if (wr_commit)
            begin
                if (sel_out)
                begin
                    output_reg_q <= out_wr[NUM_CH-1:0];
                end
                if (sel_map_a)
                begin
                    input_a_channel_map_q <= map_a_wr[NUM_CH-1:0];
                end
                if (sel_map_b)
                begin
                    input_b_channel_map_q <= map_b_wr[NUM_CH-1:0];
                end
                if (sel_pwm)
                begin
                    pwm_map_q <= pwm_wr & pwm_keep;
                end
            end
        end
    end

    // Monitor follows the pins in every mode, fail-safe included
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            input_level_monitor_q <= 2'b00;
        end
        else if (clk_en)
        begin
            input_level_monitor_q <= {pins_s2_q.in_b, pins_s2_q.in_a};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and answer

    logic [31:0] stat_word;
    logic [31:0] rdata_sel;
    logic        err_d;

    assign stat_word = (32'(sleep_mode)     << STAT_SLEEP_POS)
                     | (32'(limp_home_mode) << STAT_LIMP_POS)
                     | (32'(serial_port_en) << STAT_SERIAL_POS);

    assign rdata_sel = sel_out   ? out_ext
                     : sel_map_a ? map_a_ext
                     : sel_map_b ? map_b_ext
                     : sel_pwm   ? pwm_map_q
                     : sel_mon   ? {30'h0, input_level_monitor_q}
                     : sel_stat  ? stat_word
                     :             32'h0000_0000;

    // Sleep refuses every transfer; unmapped addresses answer with an error
    assign err_d = in_sleep | ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready  <= access;
            pslverr <= access & err_d;
            prdata  <= (access && !pwrite && !err_d) ? rdata_sel : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Channel command

    logic [NUM_CH-1:0] cmd_normal;
    logic [NUM_CH-1:0] cmd_limp;
    logic [NUM_CH-1:0] cmd_d;

    // One OR term set per channel
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        assign cmd_normal[i] = output_reg_q[i]
                             | (pwm_gen_out[0] & pwm_map_q[i])
                             | (pwm_gen_out[1] & pwm_map_q[PWM1_MAP_POS + i])
                             | (pins_s2_q.in_a & input_a_channel_map_q[i])
                             | (pins_s2_q.in_b & input_b_channel_map_q[i]);
    end

    // Fail-safe uses the fixed default channels, not any programmed map
    assign cmd_limp = ({NUM_CH{pins_s2_q.in_a}} & MAP_A_RST)
                    | ({NUM_CH{pins_s2_q.in_b}} & MAP_B_RST);

    assign cmd_d = (mode_d == MODE_LIMP)   ? cmd_limp
                 : (mode_d == MODE_NORMAL) ? cmd_normal
                 :                           {NUM_CH{1'b0}};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_on <= {NUM_CH{1'b0}};
        end
        else if (clk_en)
        begin
            channel_on <= cmd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Mode outputs

    // Detectors and serial port follow the next mode so they track the pins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uv_detect_en   <= 1'b1;
            serial_port_en <= 1'b1;
            sleep_mode     <= 1'b0;
            limp_home_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            uv_detect_en   <= (mode_d != MODE_SLEEP);
            serial_port_en <= (mode_d != MODE_SLEEP);
            sleep_mode     <= (mode_d == MODE_SLEEP);
            limp_home_mode <= (mode_d == MODE_LIMP);
        end
    end

endmodule : direct_input_mode_control

`default_nettype wire

//--- hdl/direct_input_pkg.sv
`default_nettype none

package direct_input_pkg;

    // Register byte offsets on the APB port
    localparam logic [7:0] OUTPUT_REG_OFS    = 8'h00;
    localparam logic [7:0] MAP_A_OFS         = 8'h04;
    localparam logic [7:0] MAP_B_OFS         = 8'h08;
    localparam logic [7:0] PWM_MAP_OFS       = 8'h0c;
    localparam logic [7:0] LEVEL_MONITOR_OFS = 8'h10;
    localparam logic [7:0] MODE_STATUS_OFS   = 8'h14;

    // Default channels driven by the two direct inputs
    localparam int unsigned DEF_CH_A = 2;
    localparam int unsigned DEF_CH_B = 3;

    // Field positions
    localparam int unsigned PWM1_MAP_POS    = 16;
    localparam int unsigned STAT_SLEEP_POS  = 0;
    localparam int unsigned STAT_LIMP_POS   = 1;
    localparam int unsigned STAT_SERIAL_POS = 2;

    // Values after reset
    localparam logic [31:0] OUTPUT_REG_RST = 32'h0000_0000;
    localparam logic [31:0] PWM_MAP_RST    = 32'h0000_0000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP  = 2'b01,
        MODE_LIMP   = 2'b10
    } mode_t;

    // Control pins from the host, carried together
    typedef struct packed {
        logic ctrl;
        logic in_b;
        logic in_a;
    } pins_t;

    localparam pins_t PINS_RST = 3'b000;

endpackage : direct_input_pkg

`default_nettype wire

//--- testbench/direct_input_mode_control_checker.sv
`timescale 1ns/1ps
`default_nettype none

module direct_input_mode_control_checker
    import direct_input_pkg::*;
#(
    parameter int unsigned NUM_CH = 8
)
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB answer
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    // Host pins and outputs
    input wire logic              direct_input_a,
    input wire logic              direct_input_b,
    input wire logic              ctrl_pin,
    input wire logic [NUM_CH-1:0] channel_on,
    input wire logic              uv_detect_en,
    input wire logic              serial_port_en,
    input wire logic              sleep_mode,
    input wire logic              limp_home_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts edges since reset and holds at 3; the synchronisers hold stale zeros until then
    logic [1:0] up_q;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;

    ////////////////////////////////////////////////////////////////
    property p_sleep; up_q == 2'h3 |->
        sleep_mode == $past(!ctrl_pin && !direct_input_a && !direct_input_b, 3); endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flag wrong");
    property p_limp; up_q == 2'h3 |->
        limp_home_mode == $past(!ctrl_pin && (direct_input_a || direct_input_b), 3); endproperty
    a_limp: assert property (p_limp) else $error("limp flag wrong");
    property p_uv; uv_detect_en == !sleep_mode; endproperty
    a_uv: assert property (p_uv) else $error("uv detect enable wrong");
    property p_ser; serial_port_en == !sleep_mode; endproperty
    a_ser: assert property (p_ser) else $error("serial enable wrong");
    property p_limp_ch; limp_home_mode && up_q == 2'h3 |->
        channel_on[DEF_CH_A] == $past(direct_input_a, 3) &&
        channel_on[DEF_CH_B] == $past(direct_input_b, 3); endproperty
    a_limp_ch: assert property (p_limp_ch) else $error("limp channel wrong");
    property p_sleep_ch; sleep_mode |-> channel_on == '0; endproperty
    a_sleep_ch: assert property (p_sleep_ch) else $error("channel on in sleep");
    property p_refuse; psel && penable && pready && sleep_mode |->
        pslverr && prdata == 32'h0; endproperty
    a_refuse: assert property (p_refuse) else $error("transfer not refused");
    property p_excl; !(sleep_mode && limp_home_mode); endproperty
    a_excl: assert property (p_excl) else $error("two modes at once");
endmodule : direct_input_mode_control_checker

bind direct_input_mode_control direct_input_mode_control_checker #(.NUM_CH(NUM_CH)) u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .direct_input_a,
    .direct_input_b, .ctrl_pin, .channel_on, .uv_detect_en, .serial_port_en, .sleep_mode,
    .limp_home_mode);

`default_nettype wire

//--- testbench/host_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_pin_model
    import direct_input_pkg::*;
#(
    parameter int unsigned FALL_HOLD = 4,
    parameter int unsigned RISE_HOLD = 4
)
(
    // Requested and driven pin levels
    input wire pins_t want,
    input wire logic  pclk,
    output var pins_t pins
);
    int unsigned hold_q = 0;
    pins_t       pins_q = 3'b100;
    assign pins = pins_q;

    // Inputs follow at once; the control pin waits out its hold time
    always @(posedge pclk)
    begin
        pins_q.in_a <= want.in_a;
        pins_q.in_b <= want.in_b;
        if (hold_q != 0)
            hold_q <= hold_q - 1;
        else if (want.ctrl != pins_q.ctrl)
        begin
            pins_q.ctrl <= want.ctrl;
            hold_q      <= want.ctrl ? RISE_HOLD : FALL_HOLD;
        end
    end
endmodule : host_pin_model

`default_nettype wire

//--- testbench/test_direct_input_mode_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_direct_input_mode_control
    import direct_input_pkg::*;
;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, uv, ser, slp, limp;
    logic [1:0]  pwm = 2'h0;
    logic        en = 1'b1;
    logic [7:0]  chan;
    pins_t       want = 3'b100, pins;
    int          err_total = 0, samples_checked = 0;

    always #25 pclk = ~pclk;

    direct_input_mode_control #(.NUM_CH(8)) dut (.pclk(pclk), .presetn(presetn),
        .clk_en(en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .direct_input_a(pins.in_a), .direct_input_b(pins.in_b), .ctrl_pin(pins.ctrl),
        .pwm_gen_out(pwm), .channel_on(chan), .uv_detect_en(uv), .serial_port_en(ser),
        .sleep_mode(slp), .limp_home_mode(limp));
    host_pin_model host (.want(want), .pclk(pclk), .pins(pins));

    ////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; an idle edge follows so the next setup never races the release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", exp, rd);
        chk("read error", 32'h0, {31'h0, er});
    endtask : rdchk

    // Pins settle well past the synchroniser and control hold time
    task automatic set_pins(input pins_t p);
        want <= p;
        repeat (12) @(posedge pclk);
    endtask : set_pins

    // Watchdog cuts a hang short
    initial
    begin
        repeat (5000) @(posedge pclk);
        err_total++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        rdchk(MAP_A_OFS, 32'h4);
        rdchk(MAP_B_OFS, 32'h8);
        rdchk(MODE_STATUS_OFS, 32'h4);
        set_pins(3'b101);
        chk("channel_on", 32'h04, {24'h0, chan});
        rdchk(LEVEL_MONITOR_OFS, 32'h1);
        apb(1'b1, MAP_A_OFS, 32'h81);
        apb(1'b1, OUTPUT_REG_OFS, 32'h10);
        apb(1'b1, PWM_MAP_OFS, 32'h0002_0000);
        pwm <= 2'h2;
        repeat (4) @(posedge pclk);
        chk("channel_on", 32'h93, {24'h0, chan});
        // A low enable must freeze the command even though the PWM term changes
        en <= 1'b0;
        pwm <= 2'h0;
        repeat (4) @(posedge pclk);
        chk("frozen channel_on", 32'h93, {24'h0, chan});
        en <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("channel_on", 32'h91, {24'h0, chan});
        pwm <= 2'h2;
        set_pins(3'b001);
        chk("channel_on", 32'h04, {24'h0, chan});
        chk("limp", 32'h1, {31'h0, limp});
        rdchk(LEVEL_MONITOR_OFS, 32'h1);
        rdchk(MAP_A_OFS, 32'h4);
        rdchk(OUTPUT_REG_OFS, 32'h0);
        set_pins(3'b010);
        chk("channel_on", 32'h08, {24'h0, chan});
        rdchk(LEVEL_MONITOR_OFS, 32'h2);
        set_pins(3'b000);
        chk("sleep uv serial", 32'h4, {29'h0, slp, uv, ser});
        chk("channel_on", 32'h0, {24'h0, chan});
        apb(1'b0, MAP_A_OFS, 32'h0);
        chk("sleep error", 32'h1, {31'h0, er});
        chk("sleep read data", 32'h0, rd);
        set_pins(3'b100);
        rdchk(PWM_MAP_OFS, 32'h0);
        chk("channel_on", 32'h0, {24'h0, chan});
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        print_verdict();
    end
endmodule : test_direct_input_mode_control

`default_nettype wire
